// *** sim/txc_link_properties.sv ***
// Concurrent checks on the link between configuration host and register bank
`timescale 1ns/10ps
module txc_link_properties #(
   parameter logic [7:0] VENDOR_ID_LOW = 8'hA5
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic serial_if_select,
   input wire logic pwr_dn_n,
   input wire logic reserved_in
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   a_strobes_exclusive: assert property (!(reg_wr && reg_rd))
      else $error("read and write strobes together");
   // Read data only in the cycle after a read strobe
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_id_fixed: assert property (reg_rd && reg_addr == 4'h0 && serial_if_select |=> reg_rdata == VENDOR_ID_LOW)
      else $error("identity byte wrong");
   a_reserved_a_zero: assert property (reg_rd && reg_addr == 4'h5 && serial_if_select |=> reg_rdata == 8'h00)
      else $error("reserved byte not zero");
   a_reserved_d_low: assert property (reg_rd && reg_addr == 4'hD |=> reg_rdata[3:0] == 4'h0)
      else $error("read-only nibble not zero");
   // Write then immediate read of the tuning byte returns what went in
   a_tuning_readback: assert property (reg_wr && reg_addr == 4'hC && serial_if_select ##1
      reg_rd && reg_addr == 4'hC && serial_if_select |=> reg_rdata == $past(reg_wdata, 2))
      else $error("tuning byte lost");
   a_unsel_rdata_zero: assert property (!serial_if_select |=> reg_rdata == 8'h00)
      else $error("controller answers while deselected");

   // ----------------------------------------
   // Board straps
   // ----------------------------------------
   a_reserved_low: assert property (reserved_in == 1'b0)
      else $error("reserved input not low");
   a_power_held_unsel: assert property (!serial_if_select [*2] |-> !pwr_dn_n)
      else $error("power-down released while deselected");

   c_tuning_readback: cover property (reg_wr && reg_addr == 4'hC ##1 reg_rd && reg_addr == 4'hC);
   c_id_read: cover property (reg_rd && reg_addr == 4'h0);
   c_deselect: cover property ($fell(serial_if_select));
endmodule

// *** sim/txc_register_bank_tb.sv ***
// Self-checking bench joining host and device ends of the configuration link
`timescale 1ns/10ps
`include "txc_defines.svh"
module txc_register_bank_tb;
   localparam logic [7:0] VID_LOW = 8'h6E; // Arbitrary value
   localparam logic [7:0] FREQ_LOW = 8'h2B;
   logic core_clk, rst_n, if_enable, run_request, cmd_wr, cmd_rd, irq_ack;
   logic hot_plug_state, receiver_sense, vref_low;
   logic [3:0] cmd_addr;
   logic [7:0] cmd_wdata, cmd_rdata, cfg_data, tuning_value, d;
   logic cmd_rvalid, setup_done, core_power_on, edge_rise, bus_wide, dual_edge;
   logic hsync_en, vsync_en, deskew_en, detect_out_pin;
   logic [2:0] deskew;
   int fail_count;
   int total_checks;

   txc_link_if txc_link_if_inst();
   txc_dev #(.VENDOR_ID_LOW(VID_LOW), .FREQ_LIMIT_LOW(FREQ_LOW)) txc_dev_inst (
      .core_clk(core_clk), .rst_n(rst_n), .link(txc_link_if_inst), .hot_plug_state(hot_plug_state),
      .receiver_sense(receiver_sense), .vref_low(vref_low), .cfg_data(cfg_data), .core_power_on(core_power_on),
      .edge_rise(edge_rise), .bus_wide(bus_wide), .dual_edge(dual_edge), .hsync_en(hsync_en),
      .vsync_en(vsync_en), .deskew(deskew), .deskew_en(deskew_en), .tuning_value(tuning_value),
      .detect_out_pin(detect_out_pin));
   txc_host txc_host_inst (
      .core_clk(core_clk), .rst_n(rst_n), .link(txc_link_if_inst), .if_enable(if_enable),
      .run_request(run_request), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .irq_ack(irq_ack), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .setup_done(setup_done));
   txc_link_properties #(.VENDOR_ID_LOW(VID_LOW)) txc_link_properties_inst (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(txc_link_if_inst.reg_addr),
      .reg_wdata(txc_link_if_inst.reg_wdata), .reg_wr(txc_link_if_inst.reg_wr), .reg_rd(txc_link_if_inst.reg_rd),
      .reg_rdata(txc_link_if_inst.reg_rdata), .serial_if_select(txc_link_if_inst.serial_if_select),
      .pwr_dn_n(txc_link_if_inst.pwr_dn_n), .reserved_in(txc_link_if_inst.reserved_in));

   // 25 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Leading edge keeps two writes from touching the strobe in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      cmd_wr <= 1'b1;
      cmd_addr <= a;
      cmd_wdata <= v;
      @(posedge core_clk);
      cmd_wr <= 1'b0;
   endtask

   // Starts at once, so a read may follow a write back to back
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      int n;
      cmd_rd <= 1'b1;
      cmd_addr <= a;
      @(posedge core_clk);
      cmd_rd <= 1'b0;
      for (n = 0; n < 8 && cmd_rvalid !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      if (cmd_rvalid !== 1'b1) begin
         fail_count++;
         close_out();
      end
      v = cmd_rdata;
      @(posedge core_clk);
   endtask

   task automatic ack();
      irq_ack <= 1'b1;
      @(posedge core_clk);
      irq_ack <= 1'b0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Select the link and write every writable register once
   task automatic sc_setup();
      if_enable <= 1'b1;
      run_request <= 1'b1;
      ticks(3);
      wr(4'h9, 8'h18);
      wr(4'hA, 8'hB1);
      wr(4'hC, 8'h96);
      wr(4'hD, 8'hF0);
      wr(4'hE, 8'h5A);
      wr(4'hF, 8'hA5);
      check({7'h0, setup_done}, 8'h00);
      wr(4'h8, 8'h35);
      ticks(8);
      check({7'h0, setup_done}, 8'h01);
      check({7'h0, core_power_on}, 8'h01);
   endtask

   // Field placement, read-only bytes and reserved places
   task automatic sc_fields();
      rd(4'h8, d);
      check(d, 8'h35);
      check({3'h0, vsync_en, hsync_en, dual_edge, bus_wide, edge_rise}, 8'h1A);
      rd(4'hA, d);
      check(d, {7'h58, `TXC_REC_DSK_RESERVED});
      check({4'h0, deskew, deskew_en}, 8'h0B);
      wr(4'hC, 8'h3C);
      rd(4'hC, d);
      check(d, 8'h3C);
      check(tuning_value, 8'h3C);
      rd(4'hD, d);
      check(d, {`TXC_REC_D_UPPER, 4'h0});
      rd(4'hE, d);
      check(d, `TXC_REC_E);
      wr(4'h0, 8'hFF);
      wr(4'hB, 8'h00);
      rd(4'h0, d);
      check(d, VID_LOW);
      rd(4'h6, d);
      check(d, FREQ_LOW);
      rd(4'h5, d);
      check(d, 8'h00);
      rd(4'hB, d);
      check(d, 8'hC3);
   endtask

   // Interrupt on hot-plug change, then detect source codes 0 to 4
   task automatic sc_irq_detect();
      logic [4:0] exp_tbl;
      int code;
      exp_tbl = 5'h19;
      ack();
      ticks(4);
      rd(4'h9, d);
      check({7'h0, d[0]}, 8'h01);
      check({7'h0, detect_out_pin}, 8'h01);
      hot_plug_state <= 1'b1;
      ticks(6);
      rd(4'h9, d);
      check(d, 8'h1A);
      check({7'h0, detect_out_pin}, 8'h00);
      for (code = 0; code < 5; code++) begin
         wr(4'h9, {1'b0, code[2:0], 4'h8});
         ticks(3);
         check({7'h0, detect_out_pin}, {7'h0, exp_tbl[code]});
      end
      ack();
      ticks(3);
      rd(4'h9, d);
      check(d, 8'h4B);
      wr(4'h9, 8'h18);
   endtask

   // Power-down pin, then a deselect reset in mid-run
   task automatic sc_pin_reset();
      run_request <= 1'b0;
      ticks(8);
      check({7'h0, core_power_on}, 8'h00);
      rd(4'hC, d);
      check(d, 8'h3C);
      run_request <= 1'b1;
      ticks(8);
      check({7'h0, core_power_on}, 8'h01);
      if_enable <= 1'b0;
      ticks(4);
      check({6'h0, core_power_on, detect_out_pin}, 8'h01);
      if_enable <= 1'b1;
      ticks(3);
      rd(4'h8, d);
      check(d, 8'h34);
      rd(4'h9, d);
      check(d, 8'h0B);
      rd(4'hC, d);
      check(d, 8'h3C);
      check(tuning_value, 8'h3C);
   endtask

   // Receiver-sense interrupt source, low-swing flag and sampled inputs
   task automatic sc_rx_source();
      wr(4'h9, 8'h10);
      receiver_sense <= 1'b1;
      vref_low <= 1'b1;
      cfg_data <= 8'h5A;
      ticks(6);
      rd(4'h9, d);
      check(d, 8'h96);
      check({7'h0, detect_out_pin}, 8'h00);
      rd(4'hB, d);
      check(d, 8'h5A);
      ack();
      ticks(3);
      hot_plug_state <= 1'b0;
      ticks(6);
      rd(4'h9, d);
      check(d, 8'h95);
      check({7'h0, detect_out_pin}, 8'h01);
   endtask

   // Main sequence
   initial begin
      fail_count = 0;
      total_checks = 0;
      rst_n = 1'b0;
      if_enable = 1'b0;
      run_request = 1'b0;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      irq_ack = 1'b0;
      cmd_addr = 4'h0;
      cmd_wdata = 8'h00;
      hot_plug_state = 1'b0;
      receiver_sense = 1'b0;
      vref_low = 1'b0;
      cfg_data = 8'hC3;
      ticks(16);
      rst_n <= 1'b1;
      ticks(2);
      sc_setup();
      sc_fields();
      sc_irq_detect();
      sc_pin_reset();
      sc_rx_source();
      close_out();
   end
endmodule

// *** verilog/txc_defines.svh ***
// Offsets, field positions, reset values and host settings of the transmitter register bank
`ifndef TXC_DEFINES_SVH
`define TXC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TXC_OFS_VENDOR_ID_LOW 4'h0
`define TXC_OFS_VENDOR_ID_HIGH 4'h1
`define TXC_OFS_DEVICE_ID_LOW 4'h2
`define TXC_OFS_DEVICE_ID_HIGH 4'h3
`define TXC_OFS_DEVICE_REVISION 4'h4
`define TXC_OFS_RESERVED_RO_A 4'h5
`define TXC_OFS_FREQ_LIMIT_LOW 4'h6
`define TXC_OFS_FREQ_LIMIT_HIGH 4'h7
`define TXC_OFS_INPUT_FORMAT 4'h8
`define TXC_OFS_DETECT_STATUS 4'h9
`define TXC_OFS_DESKEW 4'hA
`define TXC_OFS_CONFIG_SAMPLE 4'hB
`define TXC_OFS_TUNING 4'hC
`define TXC_OFS_RESERVED_D 4'hD
`define TXC_OFS_RESERVED_E 4'hE
`define TXC_OFS_RESERVED_F 4'hF

// ----------------------------------------
// Field positions, bit 7 is the MSB
// ----------------------------------------
`define TXC_FMT_PWR_DN 0
`define TXC_FMT_EDGE_RISE 1
`define TXC_FMT_BUS_WIDE 2
`define TXC_FMT_DUAL_EDGE 3
`define TXC_FMT_HSYNC_EN 4
`define TXC_FMT_VSYNC_EN 5
`define TXC_FMT_RESERVED_LSB 6
`define TXC_DET_IRQ 0
`define TXC_DET_HOT_PLUG 1
`define TXC_DET_RX_SENSE 2
`define TXC_DET_IRQ_SRC 3
`define TXC_DET_SRC_LSB 4
`define TXC_DET_VREF_LOW 7
`define TXC_DSK_RESERVED 0
`define TXC_DSK_EN 4
`define TXC_DSK_STEP_LSB 5
`define TXC_RSV_D_UPPER_LSB 4

// ----------------------------------------
// Reset values of the reset-affected fields
// ----------------------------------------
`define TXC_RST_PWR_DN 1'b0
`define TXC_RST_DET_SRC 3'h0

// ----------------------------------------
// Host side: reserved values and setup mask
// ----------------------------------------
`define TXC_REC_FMT_RESERVED 2'h0
`define TXC_REC_DSK_RESERVED 1'b0
`define TXC_REC_D_UPPER 4'h0
`define TXC_REC_E 8'h00
`define TXC_REC_F 8'h00
`define TXC_SETUP_MASK 16'hF700

`endif

// *** verilog/txc_dev.sv ***
// Transmitter configuration and status register bank, device end
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`include "txc_defines.svh"

module txc_dev #(
   parameter logic [7:0] VENDOR_ID_LOW = 8'hA5,   // Arbitrary value
   parameter logic [7:0] VENDOR_ID_HIGH = 8'h5A,  // Arbitrary value
   parameter logic [7:0] DEVICE_ID_LOW = 8'h3C,   // Arbitrary value
   parameter logic [7:0] DEVICE_ID_HIGH = 8'hC3,  // Arbitrary value
   parameter logic [7:0] DEVICE_REVISION = 8'h11, // Arbitrary value
   parameter logic [7:0] FREQ_LIMIT_LOW = 8'h19,
   parameter logic [7:0] FREQ_LIMIT_HIGH = 8'h2F
) (
   input wire logic core_clk,
   input wire logic rst_n,
   txc_link_if.dev link,
   input wire logic hot_plug_state,
   input wire logic receiver_sense,
   input wire logic vref_low,
   input wire logic [7:0] cfg_data,
   output logic core_power_on,
   output logic edge_rise,
   output logic bus_wide,
   output logic dual_edge,
   output logic hsync_en,
   output logic vsync_en,
   output logic [2:0] deskew,
   output logic deskew_en,
   output logic [7:0] tuning_value,
   output logic detect_out_pin
);

   // ----------------------------------------
   // State and pin synchronisers
   // ----------------------------------------
   txc_pkg::txc_dev_state_t st;
   txc_pkg::txc_dev_state_t next_st;
   logic ctrl_rst_n;
   logic [12:0] pin_vec;
   logic sy_pwr_dn_n;
   logic sy_reserved;
   logic sy_hot_plug;
   logic sy_rx_sense;
   logic sy_vref_low;
   logic [7:0] sy_cfg;
   logic monitored;
   logic det_wr;

   // Pins gathered for the two-stage synchroniser
   assign pin_vec = {link.pwr_dn_n, link.reserved_in, hot_plug_state, receiver_sense, vref_low, cfg_data};
   assign sy_pwr_dn_n = st.sync2[12];
   assign sy_reserved = st.sync2[11];
   assign sy_hot_plug = st.sync2[10];
   assign sy_rx_sense = st.sync2[9];
   assign sy_vref_low = st.sync2[8];
   assign sy_cfg = st.sync2[7:0];

   // select gates reset
   // Release is not resynchronised; the select pin is a slow board strap.
   assign ctrl_rst_n = rst_n & link.serial_if_select;

   // Interrupt source follows the source-select bit
   assign monitored = st.irq_src_hpd ? sy_hot_plug : sy_rx_sense;
   assign det_wr = link.reg_wr && (link.reg_addr == `TXC_OFS_DETECT_STATUS);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      logic [7:0] rd_val;
      rd_val = 8'h00;
      next_st = st;
      next_st.sync1 = pin_vec;
      next_st.sync2 = st.sync1;
      next_st.mon_prev = monitored;

      if (link.reg_wr) begin
         case (link.reg_addr)
            `TXC_OFS_INPUT_FORMAT: begin
               next_st.pwr_bit = link.reg_wdata[`TXC_FMT_PWR_DN];
               next_st.edge_rise = link.reg_wdata[`TXC_FMT_EDGE_RISE];
               next_st.bus_wide = link.reg_wdata[`TXC_FMT_BUS_WIDE];
               next_st.dual_edge = link.reg_wdata[`TXC_FMT_DUAL_EDGE];
               next_st.hsync_en = link.reg_wdata[`TXC_FMT_HSYNC_EN];
               next_st.vsync_en = link.reg_wdata[`TXC_FMT_VSYNC_EN];
               next_st.fmt_reserved = link.reg_wdata[`TXC_FMT_RESERVED_LSB +: 2];
            end
            `TXC_OFS_DETECT_STATUS: begin
               next_st.det_src = txc_pkg::txc_det_src_t'(link.reg_wdata[`TXC_DET_SRC_LSB +: 3]);
               next_st.irq_src_hpd = link.reg_wdata[`TXC_DET_IRQ_SRC];
            end
            `TXC_OFS_DESKEW: begin
               next_st.deskew = link.reg_wdata[`TXC_DSK_STEP_LSB +: 3];
               next_st.deskew_en = link.reg_wdata[`TXC_DSK_EN];
               next_st.deskew_reserved = link.reg_wdata[`TXC_DSK_RESERVED];
            end
            `TXC_OFS_TUNING: begin
               next_st.tuning_value = link.reg_wdata;
            end
            `TXC_OFS_RESERVED_D: begin
               next_st.reserved_d = link.reg_wdata[`TXC_RSV_D_UPPER_LSB +: 4];
            end
            `TXC_OFS_RESERVED_E: begin
               next_st.reserved_e = link.reg_wdata;
            end
            `TXC_OFS_RESERVED_F: begin
               next_st.reserved_f = link.reg_wdata;
            end
            default: begin
               next_st.reserved_e = st.reserved_e; // Read-only offsets drop the write
            end
         endcase
      end

      // change clears, change wins over set
      // A level change in the same cycle as a write of one keeps the bit at 0.
      if (monitored != st.mon_prev) begin
         next_st.monitor_change_irq = 1'b0;
      end else if (det_wr && link.reg_wdata[`TXC_DET_IRQ]) begin
         next_st.monitor_change_irq = 1'b1;
      end

      case (link.reg_addr)
         `TXC_OFS_VENDOR_ID_LOW: rd_val = VENDOR_ID_LOW;
         `TXC_OFS_VENDOR_ID_HIGH: rd_val = VENDOR_ID_HIGH;
         `TXC_OFS_DEVICE_ID_LOW: rd_val = DEVICE_ID_LOW;
         `TXC_OFS_DEVICE_ID_HIGH: rd_val = DEVICE_ID_HIGH;
         `TXC_OFS_DEVICE_REVISION: rd_val = DEVICE_REVISION;
         `TXC_OFS_RESERVED_RO_A: rd_val = 8'h00;
         `TXC_OFS_FREQ_LIMIT_LOW: rd_val = FREQ_LIMIT_LOW;
         `TXC_OFS_FREQ_LIMIT_HIGH: rd_val = FREQ_LIMIT_HIGH;
         `TXC_OFS_INPUT_FORMAT: begin
            rd_val = {st.fmt_reserved, st.vsync_en, st.hsync_en, st.dual_edge, st.bus_wide, st.edge_rise,
                      st.pwr_bit};
         end
         `TXC_OFS_DETECT_STATUS: begin
            rd_val = {sy_vref_low, st.det_src, st.irq_src_hpd, sy_rx_sense, sy_hot_plug, st.monitor_change_irq};
         end
         `TXC_OFS_DESKEW: rd_val = {st.deskew, st.deskew_en, 3'h0, st.deskew_reserved};
         `TXC_OFS_CONFIG_SAMPLE: rd_val = sy_cfg;
         `TXC_OFS_TUNING: rd_val = st.tuning_value;
         `TXC_OFS_RESERVED_D: rd_val = {st.reserved_d, 4'h0};
         `TXC_OFS_RESERVED_E: rd_val = st.reserved_e;
         `TXC_OFS_RESERVED_F: rd_val = st.reserved_f;
         default: rd_val = 8'h00;
      endcase
      next_st.rdata = link.reg_rd ? rd_val : 8'h00;

      next_st.core_on = sy_pwr_dn_n & st.pwr_bit & ~sy_reserved;

      case (st.det_src)
         txc_pkg::TXC_SRC_HIGH: next_st.detect_out = 1'b1;
         txc_pkg::TXC_SRC_IRQ: next_st.detect_out = st.monitor_change_irq;
         txc_pkg::TXC_SRC_RX_SENSE: next_st.detect_out = sy_rx_sense;
         txc_pkg::TXC_SRC_HOT_PLUG: next_st.detect_out = sy_hot_plug;
         default: next_st.detect_out = 1'b1; // Reserved codes park the pin high
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // only chosen fields reset
   // Configuration fields other than pwr_bit and det_src have no reset branch so they survive a reset pulse.
   // Synchronisers and the change detector hold through reset, so a high pin
   // does not look like a fresh level change once the controller is released.
   always_ff @(posedge core_clk or negedge ctrl_rst_n) begin
      if (!ctrl_rst_n) begin
         st.pwr_bit <= `TXC_RST_PWR_DN;
         st.det_src <= txc_pkg::TXC_SRC_HIGH;
         st.rdata <= 8'h00;
         st.core_on <= 1'b0;
         st.detect_out <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // only the core follows power-down; bank stays live
   assign core_power_on = st.core_on;
   assign edge_rise = st.edge_rise;
   assign bus_wide = st.bus_wide;
   assign dual_edge = st.dual_edge;
   assign hsync_en = st.hsync_en;
   assign vsync_en = st.vsync_en;
   assign deskew = st.deskew;
   assign deskew_en = st.deskew_en;
   assign tuning_value = st.tuning_value;
   assign detect_out_pin = st.detect_out;
   assign link.reg_rdata = st.rdata;

endmodule

// *** verilog/txc_host.sv ***
// Configuration host end: drives register writes, reads and board straps
`timescale 1ns/10ps
`include "txc_defines.svh"

module txc_host (
   input wire logic core_clk,
   input wire logic rst_n,
   txc_link_if.host link,
   input wire logic if_enable,
   input wire logic run_request,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [3:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic irq_ack,
   output logic [7:0] cmd_rdata,
   output logic cmd_rvalid,
   output logic setup_done
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   txc_pkg::txc_host_state_t st;
   txc_pkg::txc_host_state_t next_st;

   function automatic logic [7:0] txc_scrub(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      r = d;
      case (a)
         `TXC_OFS_INPUT_FORMAT: r[`TXC_FMT_RESERVED_LSB +: 2] = `TXC_REC_FMT_RESERVED;
         `TXC_OFS_DESKEW: r[`TXC_DSK_RESERVED] = `TXC_REC_DSK_RESERVED;
         `TXC_OFS_RESERVED_D: r = {`TXC_REC_D_UPPER, 4'h0};
         `TXC_OFS_RESERVED_E: r = `TXC_REC_E;
         `TXC_OFS_RESERVED_F: r = `TXC_REC_F;
         default: r = d;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.wr = 1'b0;
      next_st.rd = 1'b0;
      next_st.rvalid = 1'b0;
      next_st.rd_pend = st.rd;
      next_st.sel = if_enable;
      if (st.rd_pend) begin
         next_st.rdata = link.reg_rdata;
         next_st.rvalid = 1'b1;
      end
      // Deselecting resets the far controller, so setup starts over
      if (!st.sel) begin
         next_st.written = 16'h0000;
      end
      // Orders: write before read before interrupt acknowledge
      if (cmd_wr) begin
         next_st.wr = 1'b1;
         next_st.addr = cmd_addr;
         next_st.wdata = txc_scrub(cmd_addr, cmd_wdata);
         next_st.written[cmd_addr] = st.sel;
         if (cmd_addr == `TXC_OFS_DETECT_STATUS) begin
            next_st.shadow_det = {cmd_wdata[7:1], 1'b0}; // Plain rewrite must not acknowledge
         end
      end else if (cmd_rd) begin
         next_st.rd = 1'b1;
         next_st.addr = cmd_addr;
      end else if (irq_ack) begin
         next_st.wr = 1'b1;
         next_st.addr = `TXC_OFS_DETECT_STATUS;
         next_st.wdata = {st.shadow_det[7:1], 1'b1};
      end
      next_st.done = ((st.written & `TXC_SETUP_MASK) == `TXC_SETUP_MASK);
      // hold power-down low until set up
      next_st.pwr_dn_n = run_request & st.sel & st.done;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.reg_addr = st.addr;
   assign link.reg_wdata = st.wdata;
   assign link.reg_wr = st.wr;
   assign link.reg_rd = st.rd;
   assign link.serial_if_select = st.sel;
   assign link.pwr_dn_n = st.pwr_dn_n;
   assign link.reserved_in = 1'b0;
   assign cmd_rdata = st.rdata;
   assign cmd_rvalid = st.rvalid;
   assign setup_done = st.done;

endmodule

// *** verilog/txc_link_if.sv ***
// Link between the configuration host and the transmitter register bank
`timescale 1ns/10ps
interface txc_link_if;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic serial_if_select;
   logic pwr_dn_n;
   logic reserved_in;

   modport dev (
      input reg_addr,
      input reg_wdata,
      input reg_wr,
      input reg_rd,
      input serial_if_select,
      input pwr_dn_n,
      input reserved_in,
      output reg_rdata
   );

   modport host (
      output reg_addr,
      output reg_wdata,
      output reg_wr,
      output reg_rd,
      output serial_if_select,
      output pwr_dn_n,
      output reserved_in,
      input reg_rdata
   );
endinterface

// *** verilog/txc_pkg.sv ***
// Types shared by both ends of the transmitter configuration link
package txc_pkg;

   // ----------------------------------------
   // Detect output source codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      TXC_SRC_HIGH = 3'h0,
      TXC_SRC_IRQ = 3'h1,
      TXC_SRC_RX_SENSE = 3'h2,
      TXC_SRC_HOT_PLUG = 3'h3
   } txc_det_src_t;

   // ----------------------------------------
   // Device state
   // ----------------------------------------
   typedef struct packed {
      logic [12:0] sync1;
      logic [12:0] sync2;
      logic mon_prev;
      logic pwr_bit;
      logic edge_rise;
      logic bus_wide;
      logic dual_edge;
      logic hsync_en;
      logic vsync_en;
      logic [1:0] fmt_reserved;
      txc_det_src_t det_src;
      logic irq_src_hpd;
      logic monitor_change_irq;
      logic [2:0] deskew;
      logic deskew_en;
      logic deskew_reserved;
      logic [7:0] tuning_value;
      logic [3:0] reserved_d;
      logic [7:0] reserved_e;
      logic [7:0] reserved_f;
      logic [7:0] rdata;
      logic core_on;
      logic detect_out;
   } txc_dev_state_t;

   // ----------------------------------------
   // Host state
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic rd_pend;
      logic [7:0] rdata;
      logic rvalid;
      logic [15:0] written;
      logic done;
      logic [7:0] shadow_det;
      logic sel;
      logic pwr_dn_n;
   } txc_host_state_t;

endpackage
